// [core/aperture_regs.svh]
// Constants for the video memory aperture decoder: bases, shifts, limits.
// Assumes a 32-bit host physical address and a 32-bit coprocessor address.
`ifndef APERTURE_REGS_SVH
`define APERTURE_REGS_SVH

// ****************************************************************
// Address constants
// ****************************************************************
`define SMALL_BASE_A   32'h000A_0000
`define SMALL_BASE_B   32'h000B_0000
`define SMALL_SHIFT    16
`define MEDIUM_SHIFT   20
`define LARGE_SHIFT    22
`define MEDIUM_MIN     4'h1
`define MEDIUM_MAX     4'hF
`define LARGE_MIN      10'h004
`define ZERO32         32'h0000_0000

`endif

// [core/aperture_pkg.sv]
// Types shared by the aperture decoder.
// Assumes nothing beyond the constants header.
`default_nettype none
package aperture_pkg;

  // Configuration written at system setup time.
  typedef struct packed {
    logic        smallSelB;    // Small window at B0000 when set.
    logic        mediumEn;     // Medium window enabled by setup.
    logic [3:0]  mediumBase;   // Medium base in 1MB units.
    logic        largeEn;      // Large window enabled by setup.
    logic [9:0]  largeBase;    // Large base in 4MB units.
    logic        slotWide;     // Card sits in a 32-bit slot.
    logic        systemWide;   // Host system is 32-bit.
    logic        sysMem16M;    // System has 16MB of memory fitted.
  } aperture_cfg_t;

  // Local video memory range for the coprocessor.
  typedef struct packed {
    logic [31:0] vmBase;       // Video memory base address.
    logic [31:0] vmSize;       // Installed video memory size in bytes.
  } vm_range_t;

  // Which window claimed a host access.
  typedef enum logic [1:0] {
    HIT_NONE,
    HIT_SMALL,
    HIT_MEDIUM,
    HIT_LARGE
  } hit_t;

endpackage : aperture_pkg
`default_nettype wire

// [core/video_memory_aperture_decode.sv]
// Host window decoder and coprocessor local-memory range check.
// Assumes synchronous inputs on mclk; results are registered one cycle.
`timescale 1ns/10ps
`default_nettype none
`include "aperture_regs.svh"

module video_memory_aperture_decode
  import aperture_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire aperture_cfg_t cfg,
  input  wire logic          smallEnApp,
  input  wire logic [6:0]    windowIndex,
  input  wire logic          hostValid,
  input  wire logic [31:0]   hostAddr,
  input  wire vm_range_t     vmRange,
  input  wire logic          bmValid,
  input  wire logic [31:0]   bmAddr,
  output logic               hostClaim,
  output hit_t               hostHit,
  output logic [21:0]        vidAddr,
  output logic               bmLocal,
  output logic               bmMaster,
  output logic [31:0]        bmOffset
);

  // ****************************************************************
  // Window decode
  // ****************************************************************

  // Signals the combinational decode produces.
  logic        smallHit;         // Access falls in enabled small window.
  logic        mediumOk;         // Medium window may be decoded.
  logic        mediumHit;        // Access falls in medium window.
  logic        largeOk;          // Large window may be decoded.
  logic        largeHit;         // Access falls in large window.
  logic [31:0] smallBase;        // Chosen small window base.
  logic        claimNext;        // Next value of hostClaim.
  hit_t        hitNext;          // Next value of hostHit.
  logic [21:0] vidNext;          // Next value of vidAddr.

  // Checks that an address lies inside base .. base + size.
  function automatic logic in_range(input logic [31:0] a,
                                    input vm_range_t r);
    logic [32:0] top;
    top = {1'b0, r.vmBase} + {1'b0, r.vmSize};
    in_range = ({1'b0, a} >= {1'b0, r.vmBase}) && ({1'b0, a} < top);
  endfunction : in_range

  // Small window base follows the setup select.
  assign smallBase = cfg.smallSelB ? `SMALL_BASE_B : `SMALL_BASE_A;

  // Only the small window is under application control.
  assign smallHit = smallEnApp && hostValid &&
    (hostAddr[31:`SMALL_SHIFT] == smallBase[31:`SMALL_SHIFT]);

  // Medium window needs a legal base and no 16MB system memory.
  assign mediumOk = cfg.mediumEn && !cfg.sysMem16M &&
    (cfg.mediumBase >= `MEDIUM_MIN) &&
    (cfg.mediumBase <= `MEDIUM_MAX);
  assign mediumHit = mediumOk && hostValid &&
    (hostAddr[31:`MEDIUM_SHIFT] == {8'h00, cfg.mediumBase});

  // Large window needs a 32-bit slot and system, base at or above 16MB.
  assign largeOk = cfg.largeEn && cfg.slotWide && cfg.systemWide &&
    (cfg.largeBase >= `LARGE_MIN);
  assign largeHit = largeOk && hostValid &&
    (hostAddr[31:`LARGE_SHIFT] == cfg.largeBase);

  // Picks the hit window and forms the video memory offset.
  always_comb begin
    claimNext = 1'b0;
    hitNext   = HIT_NONE;
    vidNext   = 22'h00_0000;
    if (largeHit) begin
      // Large window covers all memory directly.
      claimNext = 1'b1;
      hitNext   = HIT_LARGE;
      vidNext   = hostAddr[21:0];
    end else if (mediumHit) begin
      // Index bits above 1MB steer the medium window.
      claimNext = 1'b1;
      hitNext   = HIT_MEDIUM;
      vidNext   = {windowIndex[6:5], hostAddr[19:0]};
    end else if (smallHit) begin
      // Index picks a 64KB slice of the buffer.
      claimNext = 1'b1;
      hitNext   = HIT_SMALL;
      vidNext   = {windowIndex[5:0], hostAddr[15:0]};
    end else begin
      // Not ours; the decoder ignores it.
      claimNext = 1'b0;
    end
  end

  // Registers the host decode result.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hostClaim <= 1'b0;
      hostHit   <= HIT_NONE;
      vidAddr   <= 22'h00_0000;
    end else begin
      hostClaim <= claimNext;
      hostHit   <= hitNext;
      vidAddr   <= vidNext;
    end
  end

  // ****************************************************************
  // Coprocessor local range
  // ****************************************************************

  // Full 32-bit compare, independent of bus width or large window.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bmLocal  <= 1'b0;
      bmMaster <= 1'b0;
      bmOffset <= `ZERO32;
    end else begin
      bmLocal  <= bmValid && in_range(bmAddr, vmRange);
      bmMaster <= bmValid && !in_range(bmAddr, vmRange);
      bmOffset <= bmAddr - vmRange.vmBase;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  sequence s_bm_req;
    bmValid && in_range(bmAddr, vmRange);
  endsequence

  property p_small_place;
    @(posedge mclk) disable iff (!reset_n)
    (hostValid && smallEnApp && !largeHit && !mediumHit &&
     hostAddr[31:16] == (cfg.smallSelB ? 16'h000B : 16'h000A))
      |=> hostClaim && hostHit == HIT_SMALL;
  endproperty
  a_small_place: assert property (p_small_place)
    else $error("Small window access not claimed.");

  property p_small_index;
    @(posedge mclk) disable iff (!reset_n)
    hitNext == HIT_SMALL |=> vidAddr == {$past(windowIndex[5:0]),
                                         $past(hostAddr[15:0])};
  endproperty
  a_small_index: assert property (p_small_index)
    else $error("Small window offset wrong.");

  property p_med_16m;
    @(posedge mclk) disable iff (!reset_n)
    cfg.sysMem16M |=> hostHit != HIT_MEDIUM;
  endproperty
  a_med_16m: assert property (p_med_16m)
    else $error("Medium window decoded with 16MB memory.");

  property p_med_range;
    @(posedge mclk) disable iff (!reset_n)
    hostHit == HIT_MEDIUM |-> $past(cfg.mediumBase) != 4'h0;
  endproperty
  a_med_range: assert property (p_med_range)
    else $error("Medium base out of range.");

  property p_med_index;
    @(posedge mclk) disable iff (!reset_n)
    hostHit == HIT_MEDIUM |-> vidAddr[21:20] == $past(windowIndex[6:5]);
  endproperty
  a_med_index: assert property (p_med_index)
    else $error("Medium window offset wrong.");

  property p_large_narrow;
    @(posedge mclk) disable iff (!reset_n)
    !(cfg.slotWide && cfg.systemWide) |=> hostHit != HIT_LARGE;
  endproperty
  a_large_narrow: assert property (p_large_narrow)
    else $error("Large window decoded on a 16-bit bus.");

  property p_large_base;
    @(posedge mclk) disable iff (!reset_n)
    hostHit == HIT_LARGE |-> $past(hostAddr[31:24]) != 8'h00;
  endproperty
  a_large_base: assert property (p_large_base)
    else $error("Large window below 16MB.");

  property p_claim_idle;
    @(posedge mclk) disable iff (!reset_n)
    !hostValid |=> !hostClaim;
  endproperty
  a_claim_idle: assert property (p_claim_idle)
    else $error("Claim without access.");

  property p_bm_local;
    @(posedge mclk) disable iff (!reset_n)
    s_bm_req |=> bmLocal && !bmMaster;
  endproperty
  a_bm_local: assert property (p_bm_local)
    else $error("Local bitmap not flagged.");

  property p_bm_master;
    @(posedge mclk) disable iff (!reset_n)
    (bmValid && !in_range(bmAddr, vmRange)) |=> bmMaster && !bmLocal;
  endproperty
  a_bm_master: assert property (p_bm_master)
    else $error("System bitmap not sent to bus master.");

  property p_bm_offset;
    @(posedge mclk) disable iff (!reset_n)
    bmLocal |-> bmOffset < $past(vmRange.vmSize);
  endproperty
  a_bm_offset: assert property (p_bm_offset)
    else $error("Local offset past memory size.");

  // An idle coprocessor must see neither a local nor a system verdict.
  property p_bm_idle;
    @(posedge mclk) disable iff (!reset_n)
    !bmValid |=> !bmLocal && !bmMaster;
  endproperty
  a_bm_idle: assert property (p_bm_idle)
    else $error("Bitmap verdict without a valid address.");

  // A large window left off by setup is never decoded.
  property p_large_off;
    @(posedge mclk) disable iff (!reset_n)
    !cfg.largeEn |=> hostHit != HIT_LARGE;
  endproperty
  a_large_off: assert property (p_large_off)
    else $error("Large window decoded while disabled.");

  // The small window only answers while the application enables it.
  property p_small_off;
    @(posedge mclk) disable iff (!reset_n)
    !smallEnApp |=> hostHit != HIT_SMALL;
  endproperty
  a_small_off: assert property (p_small_off)
    else $error("Small window decoded while disabled.");

endmodule : video_memory_aperture_decode
`default_nettype wire

// [verification/host_bus_model.sv]
// Host processor model driving the system memory bus into the decoder.
// Assumes one caller at a time; accesses start at a falling edge of mclk.
`timescale 1ns/10ps
`default_nettype none

module host_bus_model (
  input  wire logic        mclk,
  output logic             hostValid,
  output logic [31:0]      hostAddr
);
  // ****************************************************************
  // Idle bus
  // ****************************************************************
  // The bus starts idle, with an address that decodes to nothing.
  initial begin
    hostValid = 1'b0;
    hostAddr  = 32'h5A5A_5A5A;
  end

  // ****************************************************************
  // One access
  // ****************************************************************
  // The request stands for one full cycle and is then released.
  task automatic access(input logic [31:0] a);
    @(negedge mclk);
    hostValid = 1'b1;
    hostAddr  = a;
    @(negedge mclk);
    hostValid = 1'b0;
    // A released bus shows the inverse, so no stale address lingers.
    hostAddr  = ~a;
  endtask : access
endmodule : host_bus_model

`default_nettype wire

// [verification/tb_video_memory_aperture_decode.sv]
// Self-checking bench for the aperture decoder and bitmap range check.
// Assumes the host bus model and the aperture package are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb_video_memory_aperture_decode;
  import aperture_pkg::*;
  logic          mclk = 1'b0;   // 20 MHz clock.
  logic          reset_n = 1'b0; // Active low reset.
  aperture_cfg_t cfg = '0;      // Setup configuration.
  logic          smallEnApp = 1'b0;
  logic [6:0]    windowIndex = 7'h00;
  logic          hostValid, hostClaim, bmLocal, bmMaster;
  logic [31:0]   hostAddr, bmOffset;
  vm_range_t     vmRange = '0;
  logic          bmValid = 1'b0;
  logic [31:0]   bmAddr = 32'h0000_0000;
  hit_t          hostHit;
  logic [21:0]   vidAddr;
  int            n_errors = 0;
  int            n_tests = 0;

  always #25 mclk = ~mclk;

  host_bus_model u_host (.mclk(mclk), .hostValid(hostValid),
                         .hostAddr(hostAddr));

  video_memory_aperture_decode u_dut (.mclk(mclk), .reset_n(reset_n),
    .cfg(cfg), .smallEnApp(smallEnApp), .windowIndex(windowIndex),
    .hostValid(hostValid), .hostAddr(hostAddr), .vmRange(vmRange),
    .bmValid(bmValid), .bmAddr(bmAddr), .hostClaim(hostClaim),
    .hostHit(hostHit), .vidAddr(vidAddr), .bmLocal(bmLocal),
    .bmMaster(bmMaster), .bmOffset(bmOffset));

  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One host access, then its claim and window, and on a hit its offset, are judged.
  task automatic hostChk(input logic [31:0] a, input hit_t h,
                         input logic [21:0] v);
    u_host.access(a);
    chk("hostClaim", {31'h0, h != HIT_NONE}, {31'h0, hostClaim});
    chk("hostHit", {30'h0, h}, {30'h0, hostHit});
    if (h != HIT_NONE) chk("vidAddr", {10'h000, v}, {10'h000, vidAddr});
  endtask : hostChk

  // One bitmap address, then local or bus-master verdict and offset.
  task automatic bmChk(input logic v, input logic [31:0] a,
                       input logic l, input logic m);
    @(negedge mclk);
    bmValid = v;
    bmAddr  = a;
    @(negedge mclk);
    bmValid = 1'b0;
    chk("bmLocal", {31'h0, l}, {31'h0, bmLocal});
    chk("bmMaster", {31'h0, m}, {31'h0, bmMaster});
    chk("bmOffset", a - vmRange.vmBase, bmOffset);
  endtask : bmChk

  // Small window at either base, moved by the index, and gated.
  task automatic t_small;
    smallEnApp  = 1'b1;
    windowIndex = 7'h03;
    hostChk(32'h000A_1234, HIT_SMALL, 22'h03_1234);
    hostChk(32'h000B_1234, HIT_NONE, 22'h00_0000);
    cfg.smallSelB = 1'b1;
    windowIndex   = 7'h3F;
    hostChk(32'h000B_FFFF, HIT_SMALL, 22'h3F_FFFF);
    smallEnApp = 1'b0;
    hostChk(32'h000B_FFFF, HIT_NONE, 22'h00_0000);
  endtask : t_small

  // Medium window bounds, index placement and the 16MB block.
  task automatic t_medium;
    cfg.mediumEn   = 1'b1;
    cfg.mediumBase = 4'h1;
    windowIndex    = 7'h40;
    hostChk(32'h0012_3456, HIT_MEDIUM, 22'h22_3456);
    cfg.mediumBase = 4'hF;
    windowIndex    = 7'h00;
    hostChk(32'h00F0_0001, HIT_MEDIUM, 22'h00_0001);
    hostChk(32'h0012_3456, HIT_NONE, 22'h00_0000);
    cfg.sysMem16M = 1'b1;
    hostChk(32'h00F0_0001, HIT_NONE, 22'h00_0000);
    cfg.sysMem16M  = 1'b0;
    cfg.mediumBase = 4'h0;
    hostChk(32'h0000_0001, HIT_NONE, 22'h00_0000);
    cfg.mediumEn   = 1'b0;
    cfg.mediumBase = 4'h1;
    // The application enable must not open a medium window left off.
    smallEnApp = 1'b1;
    hostChk(32'h0012_3456, HIT_NONE, 22'h00_0000);
    smallEnApp = 1'b0;
  endtask : t_medium

  // Large window base limits and the bus width conditions.
  task automatic t_large;
    cfg.largeEn    = 1'b1;
    cfg.largeBase  = 10'h004;
    cfg.slotWide   = 1'b1;
    cfg.systemWide = 1'b1;
    hostChk(32'h0112_3456, HIT_LARGE, 22'h12_3456);
    cfg.largeBase = 10'h3FF;
    hostChk(32'hFFC0_0010, HIT_LARGE, 22'h00_0010);
    cfg.slotWide = 1'b0;
    hostChk(32'hFFC0_0010, HIT_NONE, 22'h00_0000);
    cfg.slotWide   = 1'b1;
    cfg.systemWide = 1'b0;
    hostChk(32'hFFC0_0010, HIT_NONE, 22'h00_0000);
    cfg.systemWide = 1'b1;
    cfg.largeBase  = 10'h003;
    hostChk(32'h00C0_0010, HIT_NONE, 22'h00_0000);
    // A legal base with the setup enable cleared claims nothing.
    cfg.largeBase = 10'h004;
    cfg.largeEn   = 1'b0;
    hostChk(32'h0112_3456, HIT_NONE, 22'h00_0000);
  endtask : t_large

  // Range edges near the top of the 32-bit space.
  task automatic t_bitmap;
    // A narrow bus and no large window must leave the compare full width.
    cfg.slotWide   = 1'b0;
    cfg.systemWide = 1'b0;
    vmRange.vmBase = 32'hFFC0_0000;
    vmRange.vmSize = 32'h0040_0000;
    bmChk(1'b1, 32'hFFC0_0000, 1'b1, 1'b0);
    bmChk(1'b1, 32'hFFFF_FFFF, 1'b1, 1'b0);
    bmChk(1'b1, 32'hFFBF_FFFF, 1'b0, 1'b1);
    vmRange.vmBase = 32'h0100_0000;
    bmChk(1'b1, 32'h0140_0000, 1'b0, 1'b1);
    bmChk(1'b0, 32'h0100_0010, 1'b0, 1'b0);
  endtask : t_bitmap

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (6) @(negedge mclk);
    chk("hostClaim in reset", 32'h0000_0000, {31'h0, hostClaim});
    chk("hostHit in reset", 32'h0000_0000, {30'h0, hostHit});
    chk("vidAddr in reset", 32'h0000_0000, {10'h000, vidAddr});
    chk("bmLocal in reset", 32'h0000_0000, {31'h0, bmLocal});
    chk("bmMaster in reset", 32'h0000_0000, {31'h0, bmMaster});
    chk("bmOffset in reset", 32'h0000_0000, bmOffset);
    reset_n = 1'b1;
    t_small();
    t_medium();
    t_large();
    t_bitmap();
    conclude();
  end

  // Watchdog: far beyond the roughly 50 cycles the scenarios need.
  initial begin
    #(1000 * 50);
    n_errors++;
    $display("unexpected watchdog: expected done seen hang");
    conclude();
  end
endmodule : tb_video_memory_aperture_decode

`default_nettype wire
